// ===== hw/oami_regs.svh
`ifndef OAMI_REGS_SVH
`define OAMI_REGS_SVH

// =====================================================================
// Clock and line rates
`define OAMI_CLK_HZ      125000000
`define OAMI_BIT_HZ      64000

// =====================================================================
// Derived cycle counts (bit period rounds down, timing pulse is half of it)
`define OAMI_BIT_CYC     (`OAMI_CLK_HZ / `OAMI_BIT_HZ)
`define OAMI_HALF_CYC    (`OAMI_BIT_CYC / 2)
`define OAMI_CNT_W       11

// =====================================================================
// Octet framing
`define OAMI_OCT_W       8
`define OAMI_IDX_W       3
`define OAMI_LAST_IDX    3'h7
`define OAMI_LOSS_PULSES 4'h8
`define OAMI_RX_DEPTH    2

`endif

// ===== hw/oami_pkg.sv
package oami_pkg;

  // Interface mode: timing from a central source, or generated here
  typedef enum logic {
    OAMI_CENTRAL,
    OAMI_CONTRA
  } oami_mode_t;

  typedef logic [7:0] oami_octet_t;

endpackage

// ===== hw/oami_buf.sv
`timescale 1ns/1ns
`include "oami_regs.svh"

module oami_buf #(
  parameter int WIDTH = `OAMI_OCT_W,
  parameter int DEPTH = `OAMI_RX_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_q;
  logic [PW-1:0]    rd_q;
  logic [PW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != (PW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= ptr_inc(wr_q);
      end
      if (pop) begin
        rd_q <= ptr_inc(rd_q);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (push && !pop) begin
      cnt_q <= cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

endmodule

// ===== hw/oami_core.sv
// Overview of operation
// - Contradirectional mode moves data at 64 kbit/s, central mode at the rate of the central timing; one bit per timing cycle.
// - Data line uses AMI with each mark held for the full bit period.
// - Contradirectional timing generator emits alternating pulses lasting half a bit, rounded down to 976 of 1953 cycles.
// - Octet phase is marked by timing polarity violations; receiver aligns on them.
// - In central mode each output data bit launches on the timing pulse leading edge.
// - In central mode each incoming data bit is sampled on the trailing edge.
// - Contradirectional mode uses separate data and timing lines per direction.
// - In contradirectional mode this line side generates timing for both directions.
// - Contradirectional receiver samples each bit on the next timing pulse leading edge.
// - Suppressing octet violations in one timing signal signals an alarm for that direction.
`timescale 1ns/1ns
`include "oami_regs.svh"

module oami_core (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire oami_pkg::oami_mode_t mode_sel,
  input  wire logic                alarm_tx_req,
  input  wire logic                alarm_rx_req,
  input  wire logic                din_p,
  input  wire logic                din_n,
  input  wire logic                tin_p,
  input  wire logic                tin_n,
  output logic                     dout_p,
  output logic                     dout_n,
  output logic                     tout_tx_p,
  output logic                     tout_tx_n,
  output logic                     tout_rx_p,
  output logic                     tout_rx_n,
  input  wire logic                tx_valid,
  output logic                     tx_ready,
  input  wire oami_pkg::oami_octet_t tx_octet,
  output logic                     rx_valid,
  input  wire logic                rx_ready,
  output oami_pkg::oami_octet_t    rx_octet,
  output logic                     rx_overrun,
  output logic                     timing_lock,
  output logic                     timing_alarm
);

  import oami_pkg::*;

  // ===================================================================
  // Declarations
  logic                   contra;
  logic [3:0]             s1_q;
  logic [3:0]             s2_q;
  logic [1:0]             tprev_q;
  logic [`OAMI_CNT_W-1:0] bit_cnt_q;
  logic                   g_start;
  logic [`OAMI_IDX_W-1:0] gen_idx_q;
  logic [`OAMI_IDX_W-1:0] gen_idx_d;
  logic                   gen_last;
  logic                   pol_tx_q;
  logic                   pol_rx_q;
  logic                   np_tx;
  logic                   np_rx;
  logic                   c_pulse;
  logic                   c_was;
  logic                   c_lead;
  logic                   c_trail;
  logic                   c_pos;
  logic                   c_pol_q;
  logic                   c_seen_q;
  logic                   c_viol;
  logic                   lead_ev;
  logic                   samp_ev;
  logic [`OAMI_IDX_W-1:0] bidx_q;
  logic [`OAMI_IDX_W-1:0] bidx_d;
  logic                   aligned;
  logic                   tx_full_q;
  oami_octet_t            tx_hold_q;
  oami_octet_t            tx_sh_q;
  oami_octet_t            tx_load;
  logic                   tx_bit;
  logic                   d_pol_q;
  logic                   d_np;
  logic                   din_bit;
  oami_octet_t            rx_sh_q;
  oami_octet_t            rx_word;
  logic                   rx_push;
  logic                   buf_ready;
  logic [3:0]             miss_q;
  logic [3:0]             idle_q;

  // ===================================================================
  // AMI polarity: a mark flips polarity, a violation repeats it
  function automatic logic ami_next(input logic pol, input logic mark, input logic viol);
    ami_next = viol ? pol : (mark ? ~pol : pol);
  endfunction

  // Bit period counter shared by the generator and the idle watchdog
  function automatic logic cnt_at(input logic [`OAMI_CNT_W-1:0] c, input int unsigned v);
    cnt_at = (c == `OAMI_CNT_W'(v));
  endfunction

  assign contra = (mode_sel == OAMI_CONTRA);

  // ===================================================================
  // Line input synchronisers
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q    <= 4'h0;
      s2_q    <= 4'h0;
      tprev_q <= 2'h0;
    end else begin
      s1_q    <= {din_p, din_n, tin_p, tin_n};
      s2_q    <= s1_q;
      tprev_q <= s2_q[1:0];
    end
  end

  assign din_bit = s2_q[3] | s2_q[2];

  // ===================================================================
  // Local timing generator (contradirectional)
  always_ff @(posedge clk) begin
    if (rst) begin
      bit_cnt_q <= '0;
    end else if (cnt_at(bit_cnt_q, `OAMI_BIT_CYC - 1)) begin
      bit_cnt_q <= '0;
    end else begin
      bit_cnt_q <= bit_cnt_q + 1'b1;
    end
  end

  assign g_start   = cnt_at(bit_cnt_q, 0);
  assign gen_idx_d = gen_idx_q + 3'h1;
  assign gen_last  = (gen_idx_d == `OAMI_LAST_IDX);
  assign np_tx     = ami_next(pol_tx_q, 1'b1, gen_last && !alarm_tx_req);
  assign np_rx     = ami_next(pol_rx_q, 1'b1, gen_last && !alarm_rx_req);

  always_ff @(posedge clk) begin
    if (rst) begin
      gen_idx_q <= `OAMI_LAST_IDX;
      pol_tx_q  <= 1'b0;
      pol_rx_q  <= 1'b0;
    end else if (g_start) begin
      gen_idx_q <= gen_idx_d;
      pol_tx_q  <= np_tx;
      pol_rx_q  <= np_rx;
    end
  end

  // Both timing pairs driven from here, pulses held half a bit rounded down (976 of 1953 cycles)
  always_ff @(posedge clk) begin
    if (rst || !contra) begin
      tout_tx_p <= 1'b0;
      tout_tx_n <= 1'b0;
      tout_rx_p <= 1'b0;
      tout_rx_n <= 1'b0;
    end else if (g_start) begin
      tout_tx_p <= ~np_tx;
      tout_tx_n <= np_tx;
      tout_rx_p <= ~np_rx;
      tout_rx_n <= np_rx;
    end else if (cnt_at(bit_cnt_q, `OAMI_HALF_CYC)) begin
      tout_tx_p <= 1'b0;
      tout_tx_n <= 1'b0;
      tout_rx_p <= 1'b0;
      tout_rx_n <= 1'b0;
    end
  end

  // ===================================================================
  // Central timing receiver: any duty accepted, edges and polarity only
  assign c_pulse = s2_q[1] | s2_q[0];
  assign c_was   = tprev_q[1] | tprev_q[0];
  assign c_lead  = c_pulse && !c_was;
  assign c_trail = !c_pulse && c_was;
  assign c_pos   = s2_q[0];
  assign c_viol  = c_lead && c_seen_q && (c_pos == c_pol_q);

  always_ff @(posedge clk) begin
    if (rst) begin
      c_pol_q  <= 1'b0;
      c_seen_q <= 1'b0;
    end else if (c_lead) begin
      c_pol_q  <= c_pos;
      c_seen_q <= 1'b1;
    end
  end

  // ===================================================================
  // Bit events and octet position, common to both modes
  assign lead_ev = contra ? g_start : c_lead;
  assign samp_ev = contra ? g_start : c_trail;
  assign bidx_d  = contra ? gen_idx_d : (c_viol ? `OAMI_LAST_IDX : bidx_q + 3'h1);
  assign aligned = contra || timing_lock;

  always_ff @(posedge clk) begin
    if (rst) begin
      bidx_q <= `OAMI_LAST_IDX;
    end else if (lead_ev) begin
      bidx_q <= bidx_d;
    end
  end

  // ===================================================================
  // Transmit path: one held octet, shifted out MSB first
  assign tx_ready = !tx_full_q;
  assign tx_load  = tx_full_q ? tx_hold_q : 8'h00;
  assign tx_bit   = (bidx_d == 3'h0) ? tx_load[7] : tx_sh_q[7];
  assign d_np     = ami_next(d_pol_q, tx_bit, 1'b0);

  always_ff @(posedge clk) begin
    if (tx_valid && tx_ready) begin
      tx_hold_q <= tx_octet;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_full_q <= 1'b0;
    end else if (tx_valid && tx_ready) begin
      tx_full_q <= 1'b1;
    end else if (lead_ev && aligned && bidx_d == 3'h0) begin
      tx_full_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_sh_q <= 8'h00;
    end else if (lead_ev) begin
      tx_sh_q <= (bidx_d == 3'h0) ? {tx_load[6:0], 1'b0} : {tx_sh_q[6:0], 1'b0};
    end
  end

  // Full-duty AMI: level held from one launch to the next
  always_ff @(posedge clk) begin
    if (rst) begin
      d_pol_q <= 1'b1;
      dout_p  <= 1'b0;
      dout_n  <= 1'b0;
    end else if (lead_ev) begin
      d_pol_q <= d_np;
      dout_p  <= aligned && tx_bit && !d_np;
      dout_n  <= aligned && tx_bit && d_np;
    end
  end

  // ===================================================================
  // Receive path: sampled bits gathered into octets, last bit closes one
  assign rx_word = {rx_sh_q[6:0], din_bit};
  assign rx_push = samp_ev && aligned && (bidx_q == `OAMI_LAST_IDX);

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_sh_q <= 8'h00;
    end else if (samp_ev) begin
      rx_sh_q <= rx_word;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_overrun <= 1'b0;
    end else begin
      rx_overrun <= rx_push && !buf_ready;
    end
  end

  oami_buf #(
    .WIDTH (`OAMI_OCT_W),
    .DEPTH (`OAMI_RX_DEPTH)
  ) u_rx_buf (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (rx_push),
    .in_ready  (buf_ready),
    .in_data   (rx_word),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_octet)
  );

  // ===================================================================
  // Octet timing monitor: pulses without violation, and silent bit periods
  always_ff @(posedge clk) begin
    if (rst) begin
      idle_q <= 4'h0;
    end else if (contra || c_lead) begin
      idle_q <= 4'h0;
    end else if (g_start && idle_q != `OAMI_LOSS_PULSES) begin
      idle_q <= idle_q + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      miss_q       <= 4'h0;
      timing_lock  <= 1'b0;
      timing_alarm <= 1'b0;
    end else if (contra) begin
      miss_q       <= 4'h0;
      timing_lock  <= 1'b1;
      timing_alarm <= 1'b0;
    end else if (c_viol) begin
      miss_q       <= 4'h0;
      timing_lock  <= 1'b1;
      timing_alarm <= 1'b0;
    end else if (c_lead && miss_q != `OAMI_LOSS_PULSES) begin
      miss_q <= miss_q + 4'h1;
      if (miss_q + 4'h1 == `OAMI_LOSS_PULSES) begin
        timing_lock  <= 1'b0;
        timing_alarm <= 1'b1;
      end
    end else if (idle_q == `OAMI_LOSS_PULSES) begin
      timing_lock  <= 1'b0;
      timing_alarm <= 1'b1;
    end
  end

endmodule

// ===== bench/oami_core_properties.sv
`timescale 1ns/1ns
module oami_core_properties (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire oami_pkg::oami_mode_t mode_sel,
  input  wire logic                 alarm_tx_req,
  input  wire logic                 dout_p,
  input  wire logic                 dout_n,
  input  wire logic                 tout_tx_p,
  input  wire logic                 tout_tx_n,
  input  wire logic                 tx_valid,
  input  wire logic                 tx_ready,
  input  wire logic                 rx_valid,
  input  wire logic                 rx_overrun,
  input  wire logic                 timing_lock
);
  import oami_pkg::*;
  logic [10:0] hi_q, per_q;
  logic [2:0]  idx_q;
  logic        neg_q, pos_q, pulse;

  // ==========
  // Pulse width, bit period, slot index and last polarities
  assign pulse = tout_tx_p | tout_tx_n;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  always_ff @(posedge clk)
    hi_q <= (rst || !pulse) ? 11'h000 : hi_q + 11'h001;
  always_ff @(posedge clk)
    per_q <= (rst || (per_q == 11'h000 && !$rose(pulse))) ? 11'h000 :
             ($rose(pulse) ? 11'h001 : per_q + 11'h001);
  always_ff @(posedge clk)
    if (rst) begin
      idx_q <= 3'h7;
      neg_q <= 1'b0;
    end else if ($rose(pulse)) begin
      idx_q <= idx_q + 3'h1;
      neg_q <= tout_tx_n;
    end
  always_ff @(posedge clk)
    if (rst)
      pos_q <= 1'b0;
    else if ($rose(dout_p) || $rose(dout_n))
      pos_q <= dout_p;

  a_rails_exclusive: assert property (!(dout_p && dout_n) && !(tout_tx_p && tout_tx_n))
    else $error("both rails high");
  a_mark_alternates: assert property ($rose(dout_p) || $rose(dout_n) |-> dout_p != pos_q)
    else $error("mark polarity repeated");
  a_launch_on_pulse: assert property (mode_sel == OAMI_CONTRA && $changed({dout_p, dout_n}) |-> $rose(pulse))
    else $error("data changed off timing instant");
  a_pulse_half_bit: assert property ($fell(pulse) |-> hi_q == 11'h3D0)
    else $error("timing pulse width wrong");
  a_bit_period: assert property ($rose(pulse) && per_q != 11'h000 |-> per_q == 11'h7A1)
    else $error("bit period wrong");
  a_violation_slot: assert property ($rose(pulse) && tout_tx_n == neg_q |-> idx_q == 3'h6 && !alarm_tx_req)
    else $error("violation in wrong slot");
  a_violation_present: assert property ($rose(pulse) && idx_q == 3'h6 && !alarm_tx_req |-> tout_tx_n == neg_q)
    else $error("octet violation missing");
  a_take_drops_ready: assert property (tx_valid && tx_ready |=> !tx_ready)
    else $error("ready held after take");
  a_overrun_full: assert property (rx_overrun |-> $past(rx_valid))
    else $error("overrun with buffer empty");
  a_contra_locked: assert property (mode_sel == OAMI_CONTRA && $past(rst, 2) == 1'b0 |-> timing_lock)
    else $error("no lock in contra mode");
endmodule

bind oami_core oami_core_properties chk_i (.clk, .rst, .mode_sel, .alarm_tx_req, .dout_p, .dout_n, .tout_tx_p,
  .tout_tx_n, .tx_valid, .tx_ready, .rx_valid, .rx_overrun, .timing_lock);

// ===== bench/oami_far_model.sv
`timescale 1ns/1ns
module oami_far_model (
  input  wire oami_pkg::oami_mode_t mode_sel,
  input  wire logic                 run,
  input  wire logic                 sup,
  input  wire logic                 dout_p,
  input  wire logic                 dout_n,
  input  wire logic                 tout_rx_p,
  input  wire logic                 tout_rx_n,
  output logic                      din_p,
  output logic                      din_n,
  output logic                      tin_p,
  output logic                      tin_n
);
  import oami_pkg::*;
  logic [2:0] idx;
  logic       neg;
  logic       dp = 1'b0;
  logic       dn = 1'b0;

  // ==========
  // Central source: 125 ns bits, 70 ns pulses, still when not running
  initial begin
    {idx, neg, tin_p, tin_n} = 6'h3C;
    #3;
    forever begin
      if (run && mode_sel == OAMI_CENTRAL) begin
        idx = idx + 3'h1;
        if (idx != 3'h7 || sup)
          neg = !neg;
        {tin_p, tin_n} = {!neg, neg};
        #70;
        {tin_p, tin_n} = 2'b00;
        #55;
      end else
        #125;
    end
  end

  // Service side sends a bit back only after the pulse that releases it
  always @(posedge (tout_rx_p | tout_rx_n)) begin
    #202;
    {dp, dn} = {dout_p, dout_n};
  end
  assign din_p = (mode_sel == OAMI_CONTRA) ? dp : dout_p;
  assign din_n = (mode_sel == OAMI_CONTRA) ? dn : dout_n;
endmodule

// ===== bench/tb.sv
`timescale 1ns/1ns
module tb;
  import oami_pkg::*;
  logic        clk, rst, alarm_tx_req, alarm_rx_req, din_p, din_n, tin_p, tin_n, run, sup, lt, lr;
  logic        dout_p, dout_n, tout_tx_p, tout_tx_n, tout_rx_p, tout_rx_n, tx_valid, tx_ready;
  logic        rx_valid, rx_ready, rx_overrun, timing_lock, timing_alarm;
  oami_mode_t  mode_sel;
  oami_octet_t tx_octet, rx_octet;
  oami_octet_t rxq[$];
  int          n_mismatch, compares, n_ovr, vt, vr;

  oami_core oami_core_i (.clk, .rst, .mode_sel, .alarm_tx_req, .alarm_rx_req, .din_p, .din_n, .tin_p,
    .tin_n, .dout_p, .dout_n, .tout_tx_p, .tout_tx_n, .tout_rx_p, .tout_rx_n, .tx_valid, .tx_ready,
    .tx_octet, .rx_valid, .rx_ready, .rx_octet, .rx_overrun, .timing_lock, .timing_alarm);
  oami_far_model oami_far_model_i (.mode_sel, .run, .sup, .dout_p, .dout_n, .tout_rx_p, .tout_rx_n,
    .din_p, .din_n, .tin_p, .tin_n);

  // ==========
  // Monitors: nonzero octets, overruns, timing violations
  always @(posedge clk) begin
    if (rx_valid === 1'b1 && rx_ready && rx_octet !== 8'h00)
      rxq.push_back(rx_octet);
    if (rx_overrun === 1'b1)
      n_ovr++;
    if ($rose(tout_tx_p | tout_tx_n)) begin
      vt += (tout_tx_n == lt);
      lt = tout_tx_n;
    end
    if ($rose(tout_rx_p | tout_rx_n)) begin
      vr += (tout_rx_n == lr);
      lr = tout_rx_n;
    end
  end

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic do_reset(input oami_mode_t m);
    rst <= 1'b1;
    mode_sel <= m;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask

  task automatic send(input oami_octet_t v);
    int k;
    tx_octet <= v;
    tx_valid <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (tx_ready !== 1'b1 && k < 40000);
    tx_valid <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_until(ref logic s, input logic v, input int lim);
    for (int k = 0; k < lim && s !== v; k++) @(posedge clk);
  endtask

  task automatic t_central_loop();
    run <= 1'b1;
    wait_until(timing_lock, 1'b1, 3000);
    cmp(timing_lock, 8'h01);
    rxq.delete();
    send(8'hA5);
    send(8'h3C);
    send(8'h81);
    for (int k = 0; k < 3000 && rxq.size() < 3; k++) @(posedge clk);
    cmp(rxq[0], 8'hA5);
    cmp(rxq[1], 8'h3C);
    cmp(rxq[2], 8'h81);
  endtask

  task automatic t_buffer_stall();
    rx_ready <= 1'b0;
    n_ovr = 0;
    send(8'h66);
    repeat (600) @(posedge clk);
    cmp({rx_valid, n_ovr > 0}, 8'h03);
    rxq.delete();
    rx_ready <= 1'b1;
    repeat (3) @(posedge clk);
    cmp({7'h00, rx_valid}, 8'h00);
    cmp(rxq[0], 8'h66);
  endtask

  task automatic t_alarm();
    sup <= 1'b1;
    wait_until(timing_alarm, 1'b1, 3000);
    cmp(timing_alarm, 8'h01);
    sup <= 1'b0;
    wait_until(timing_lock, 1'b0, 10);
    for (int k = 0; k < 3000 && {timing_alarm, timing_lock} !== 2'b01; k++) @(posedge clk);
    cmp({timing_alarm, timing_lock}, 8'h01);
  endtask

  task automatic t_contra_loop();
    run <= 1'b0;
    wait_until(timing_alarm, 1'b1, 20000);
    cmp({7'h00, timing_alarm}, 8'h01);
    alarm_rx_req <= 1'b1;
    lt = 1'b0;
    lr = 1'b0;
    do_reset(OAMI_CONTRA);
    vt = 0;
    vr = 0;
    rxq.delete();
    send(8'h5A);
    send(8'hC3);
    for (int k = 0; k < 70000 && rxq.size() < 2; k++) @(posedge clk);
    cmp(rxq[0], 8'h5A);
    cmp(rxq[1], 8'hC3);
    cmp({vt > 1, vr == 0, timing_lock}, 8'h07);
  endtask

  task automatic print_verdict();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    repeat (95000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end

  initial begin
    {rst, alarm_tx_req, alarm_rx_req, tx_valid, rx_ready, run, sup} = 7'h44;
    {lt, lr} = 2'b00;
    mode_sel = OAMI_CENTRAL;
    tx_octet = 8'h00;
    do_reset(OAMI_CENTRAL);
    cmp({tx_ready, rx_valid, timing_lock, timing_alarm, dout_p, dout_n, tout_tx_p, tout_rx_p}, 8'h80);
    t_central_loop();
    t_buffer_stall();
    t_alarm();
    t_contra_loop();
    print_verdict();
  end
endmodule
